// ### hw/tvm_pkg.sv
// Package: constants and types for the tiled volume mip layout block
package tvm_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [11:0] TVM_OFF_CTRL = 12'h0000;
   localparam logic [11:0] TVM_OFF_FMT = 12'h0004;
   localparam logic [11:0] TVM_OFF_LEVEL = 12'h0008;
   localparam logic [11:0] TVM_OFF_BASE = 12'h000C;
   localparam logic [11:0] TVM_OFF_DESC = 12'h0010;
   localparam logic [11:0] TVM_OFF_FAULT = 12'h0014;
   localparam logic [11:0] TVM_OFF_POS = 12'h0018;
   localparam logic [11:0] TVM_OFF_ALIGN = 12'h001C;
   localparam logic [11:0] TVM_OFF_UNIT = 12'h0020;
   localparam logic [11:0] TVM_OFF_STAT = 12'h0024;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int TVM_CTRL_TR_LSB = 0;   // tiled_resource_field, 2 bits
   localparam int TVM_CTRL_TILE_BIT = 2; // 1 = small_tile_mode
   localparam int TVM_FMT_BPE_LSB = 0;   // element width code, 3 bits
   localparam int TVM_FMT_SRC_LSB = 4;   // surface source, 2 bits
   localparam int TVM_FMT_CLS_LSB = 8;   // format class, 3 bits
   localparam int TVM_FMT_FW_LSB = 12;   // block_footprint_width, 4 bits
   localparam int TVM_FMT_FH_LSB = 16;   // block_footprint_height, 4 bits
   localparam int TVM_LVL_CUR_LSB = 0;   // level asked for, 4 bits
   localparam int TVM_LVL_FIRST_LSB = 8; // tail_first_level, 4 bits
   localparam int TVM_BASE_U_LSB = 0;    // w1, 16 bits
   localparam int TVM_BASE_V_LSB = 16;   // h0+h2+..+h(S-1), 16 bits
   localparam int TVM_DESC_I_LSB = 0;    // descriptor align i, 8 bits
   localparam int TVM_DESC_J_LSB = 8;    // descriptor align j, 8 bits

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] TVM_RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] TVM_RST_FMT = 32'h0000_0002;
   localparam logic [31:0] TVM_RST_LEVEL = 32'h0000_0000;
   localparam logic [31:0] TVM_RST_BASE = 32'h0000_0000;
   localparam logic [31:0] TVM_RST_DESC = 32'h0000_0404;

   // ****************************************************************
   // Encodings
   // ****************************************************************
   localparam logic [1:0] TVM_NO_TILED_RESOURCE = 2'h0;
   localparam logic [2:0] TVM_BPE_8 = 3'h0;
   localparam logic [2:0] TVM_BPE_16 = 3'h1;
   localparam logic [2:0] TVM_BPE_32 = 3'h2;
   localparam logic [2:0] TVM_BPE_64 = 3'h3;
   localparam logic [2:0] TVM_BPE_128 = 3'h4;
   localparam logic [3:0] TVM_SMALL_SLOT_SHIFT = 4'h4;

   typedef enum logic [1:0] {
      TVM_SRC_DESCRIPTOR = 2'h0,
      TVM_SRC_DEPTH = 2'h1,
      TVM_SRC_STENCIL = 2'h2
   } tvm_src_e;

   typedef enum logic [2:0] {
      TVM_CLS_OTHER = 3'h0,
      TVM_CLS_BLOCK = 3'h1,   // block_compressed / ericsson_style / alpha
      TVM_CLS_LEGACY = 3'h2,  // legacy_block_format
      TVM_CLS_ADAPTIVE = 3'h3,// adaptive_block_format
      TVM_CLS_DEPTH16 = 3'h4  // sixteen_bit_depth_format
   } tvm_cls_e;

   typedef enum logic [2:0] {
      TVM_ST_IDLE = 3'b001,
      TVM_ST_CALC = 3'b010,
      TVM_ST_DONE = 3'b100
   } tvm_state_e;

endpackage : tvm_pkg

// ### hw/tvm_layout.sv
// Top: mip tail placement, volume alignment and alignment unit lookups
`timescale 1ns/1ps

module tvm_layout (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fetch_valid,
   input wire logic fetch_unmapped,
   output logic xlate_error_r
);
   import tvm_pkg::*;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [31:0] ctrl_r, fmt_r, level_r, base_r, desc_r;
   logic [31:0] pos_r, align_r, unit_r;
   logic fault_r;
   logic sup_err_r;
   logic tail_r;
   tvm_state_e state_r;
   logic fetch_valid_m, fetch_valid_s, unmapped_m, unmapped_s;

   logic wr_en, rd_en, addr_ok;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= TVM_OFF_STAT);
   assign pslverr = psel && penable && !addr_ok;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = val[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= TVM_RST_CTRL;
         fmt_r <= TVM_RST_FMT;
         level_r <= TVM_RST_LEVEL;
         base_r <= TVM_RST_BASE;
         desc_r <= TVM_RST_DESC;
      end else if (wr_en) begin
         if (paddr == TVM_OFF_CTRL) begin
            ctrl_r <= merge(ctrl_r, pwdata, pstrb);
         end else if (paddr == TVM_OFF_FMT) begin
            fmt_r <= merge(fmt_r, pwdata, pstrb);
         end else if (paddr == TVM_OFF_LEVEL) begin
            level_r <= merge(level_r, pwdata, pstrb);
         end else if (paddr == TVM_OFF_BASE) begin
            base_r <= merge(base_r, pwdata, pstrb);
         end else if (paddr == TVM_OFF_DESC) begin
            desc_r <= merge(desc_r, pwdata, pstrb);
         end
      end
   end

   // ****************************************************************
   // Field extraction
   // ****************************************************************
   logic [1:0] tiled_resource_field;
   logic small_tile_mode;
   logic [2:0] bpe;
   logic [1:0] src;
   logic [2:0] cls;
   logic [3:0] fw, fh, cur_lvl, tail_first_level;
   assign tiled_resource_field = ctrl_r[TVM_CTRL_TR_LSB +: 2];
   assign small_tile_mode = ctrl_r[TVM_CTRL_TILE_BIT];
   assign bpe = fmt_r[TVM_FMT_BPE_LSB +: 3];
   assign src = fmt_r[TVM_FMT_SRC_LSB +: 2];
   assign cls = fmt_r[TVM_FMT_CLS_LSB +: 3];
   assign fw = fmt_r[TVM_FMT_FW_LSB +: 4];
   assign fh = fmt_r[TVM_FMT_FH_LSB +: 4];
   assign cur_lvl = level_r[TVM_LVL_CUR_LSB +: 4];
   assign tail_first_level = level_r[TVM_LVL_FIRST_LSB +: 4];

   // ****************************************************************
   // Slot offset table, large-tile slot numbering
   // ****************************************************************
   // Packed {u,v,r} 8 bits each; one row per slot, five widths
   function automatic logic [23:0] slot_ofs(input logic [3:0] slot,
                                            input logic [2:0] w);
      logic [23:0] o;
      logic n;
      o = 24'h00_0000;
      n = (w == TVM_BPE_16) || (w == TVM_BPE_8);
      case (slot)
         4'd0: o = (w == TVM_BPE_128) ? 24'h08_0000 :
                   (w == TVM_BPE_8) ? 24'h20_0000 : 24'h10_0000;
         4'd1: o = (w >= TVM_BPE_64) ? 24'h00_0800 : 24'h00_1000;
         4'd2: o = n ? 24'h00_0010 : 24'h00_0008;
         4'd3: o = (w == TVM_BPE_128) ? 24'h04_0000 :
                   (w == TVM_BPE_8) ? 24'h10_0000 : 24'h08_0000;
         4'd4: o = (w >= TVM_BPE_64) ? 24'h00_0400 : 24'h00_0800;
         4'd5: o = n ? 24'h00_0008 : 24'h00_0004;
         4'd6: o = (w == TVM_BPE_128) ? 24'h03_0000 :
                   (w == TVM_BPE_64) ? 24'h06_0000 :
                   (w == TVM_BPE_32) ? 24'h04_0400 : 24'h00_0404;
         4'd7: o = (w == TVM_BPE_128) ? 24'h02_0000 :
                   (w == TVM_BPE_64) ? 24'h04_0000 : 24'h00_0400;
         4'd8, 4'd9, 4'd10, 4'd11: begin
            o[7:0] = 8'(4'd11 - slot);
            if (n) begin
               o[7:0] = 8'(4'd15 - slot);
            end else if (w == TVM_BPE_128) begin
               o[23:16] = 8'h01;
            end else if (w == TVM_BPE_64) begin
               o[23:16] = 8'h02;
            end else begin
               o[23:16] = 8'h04;
            end
         end
         default: o = {16'h0000, 8'(4'd15 - slot)};
      endcase
      return o;
   endfunction : slot_ofs

   // ****************************************************************
   // Alignment lookups
   // ****************************************************************
   // Packed {h,v,d} 8 bits each
   function automatic logic [23:0] vol_align(input logic sm,
                                             input logic [2:0] w);
      logic [23:0] a;
      a = 24'h00_0000;
      if (!sm) begin
         case (w)
            TVM_BPE_128: a = 24'h10_1010;
            TVM_BPE_64: a = 24'h20_1010;
            TVM_BPE_32: a = 24'h20_2010;
            TVM_BPE_16: a = 24'h20_2020;
            TVM_BPE_8: a = 24'h40_2020;
            default: a = 24'h00_0000;
         endcase
      end else begin
         case (w)
            TVM_BPE_128: a = 24'h04_0808;
            TVM_BPE_64: a = 24'h08_0808;
            TVM_BPE_32: a = 24'h08_1008;
            TVM_BPE_16: a = 24'h08_1010;
            TVM_BPE_8: a = 24'h10_1010;
            default: a = 24'h00_0000;
         endcase
      end
      return a;
   endfunction : vol_align

   logic bpe_ok;
   assign bpe_ok = (bpe <= TVM_BPE_128);

   // ****************************************************************
   // Alignment unit
   // ****************************************************************
   logic [15:0] unit_nxt;
   always_comb begin
      unit_nxt = desc_r[15:0];
      if (src == TVM_SRC_DEPTH) begin
         unit_nxt = (cls == TVM_CLS_DEPTH16) ? 16'h0408 : 16'h0404;
      end else if (src == TVM_SRC_STENCIL) begin
         unit_nxt = 16'h0808;
      end else if (cls == TVM_CLS_BLOCK) begin
         unit_nxt = 16'h0404;
      end else if (cls == TVM_CLS_LEGACY) begin
         unit_nxt = 16'h0408;
      end else if (cls == TVM_CLS_ADAPTIVE) begin
         unit_nxt = {2'b00, fh, 2'b00, 4'h0, fw};
      end
   end

   // ****************************************************************
   // Position computation
   // ****************************************************************
   // Software supplies the tail base; level sizes are not visible here
   logic in_tail_nxt;
   logic [3:0] rel_lvl, slot_nxt;
   logic [23:0] ofs_nxt;
   logic [31:0] pos_nxt;
   logic slot_err_nxt;
   always_comb begin
      in_tail_nxt = (tiled_resource_field != TVM_NO_TILED_RESOURCE) &&
                    (cur_lvl >= tail_first_level);
      rel_lvl = cur_lvl - tail_first_level;
      // Small tile has no slots 0-3; slots shift up by four in lookup
      slot_nxt = small_tile_mode ? rel_lvl + TVM_SMALL_SLOT_SHIFT
                                 : rel_lvl;
      slot_err_nxt = small_tile_mode && (rel_lvl > 4'd11);
      ofs_nxt = slot_ofs(slot_nxt, bpe);
      // No table row for unsupported widths: stay at the tail base
      if (!bpe_ok) begin
         ofs_nxt = 24'h00_0000;
      end
      // Offsets are to the front upper left of each slot
      pos_nxt = base_r;
      if (in_tail_nxt) begin
         pos_nxt[15:0] = base_r[15:0] + {8'h00, ofs_nxt[23:16]};
         pos_nxt[31:16] = base_r[31:16] + {8'h00, ofs_nxt[15:8]};
      end
   end

   // ****************************************************************
   // Settle sequencer
   // ****************************************************************
   // One-cycle settle so all reads see a consistent result set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= TVM_ST_IDLE;
      end else begin
         case (state_r)
            TVM_ST_IDLE: state_r <= TVM_ST_CALC;
            TVM_ST_CALC: state_r <= TVM_ST_DONE;
            TVM_ST_DONE: state_r <= wr_en ? TVM_ST_CALC : TVM_ST_DONE;
            default: state_r <= TVM_ST_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Result registers
   // ****************************************************************
   // Recomputed every cycle; a write only restarts the done flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_r <= 32'h0000_0000;
         align_r <= 32'h0000_0000;
         unit_r <= 32'h0000_0000;
         tail_r <= 1'b0;
         sup_err_r <= 1'b0;
      end else begin
         pos_r <= pos_nxt;
         tail_r <= in_tail_nxt;
         // Depth of the slot in bits 31:24 of the alignment word
         align_r <= {(in_tail_nxt ? ofs_nxt[7:0] : 8'h00),
                     vol_align(small_tile_mode, bpe)};
         unit_r <= {16'h0000, unit_nxt};
         sup_err_r <= !bpe_ok || (in_tail_nxt && slot_err_nxt);
      end
   end

   // ****************************************************************
   // Translation fault on overfetch
   // ****************************************************************
   // Valid and unmapped share one synchroniser depth so they stay paired
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_valid_m <= 1'b0;
         fetch_valid_s <= 1'b0;
         unmapped_m <= 1'b0;
         unmapped_s <= 1'b0;
      end else begin
         fetch_valid_m <= fetch_valid;
         fetch_valid_s <= fetch_valid_m;
         unmapped_m <= fetch_unmapped;
         unmapped_s <= unmapped_m;
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_r <= 1'b0;
      end else if (fetch_valid_s && unmapped_s) begin
         fault_r <= 1'b1;
      end else if (wr_en && paddr == TVM_OFF_FAULT && pstrb[0] &&
                   pwdata[0]) begin
         fault_r <= 1'b0;
      end
   end
   assign xlate_error_r = fault_r;

   // ****************************************************************
   // Read mux
   // ****************************************************************
   // Combinational so reads answer with zero wait states; trades a
   // register stage on read data for a simpler bus
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         if (paddr == TVM_OFF_CTRL) begin
            prdata = ctrl_r;
         end else if (paddr == TVM_OFF_FMT) begin
            prdata = fmt_r;
         end else if (paddr == TVM_OFF_LEVEL) begin
            prdata = level_r;
         end else if (paddr == TVM_OFF_BASE) begin
            prdata = base_r;
         end else if (paddr == TVM_OFF_DESC) begin
            prdata = desc_r;
         end else if (paddr == TVM_OFF_FAULT) begin
            prdata = {31'h0000_0000, fault_r};
         end else if (paddr == TVM_OFF_POS) begin
            prdata = pos_r;
         end else if (paddr == TVM_OFF_ALIGN) begin
            prdata = align_r;
         end else if (paddr == TVM_OFF_UNIT) begin
            prdata = unit_r;
         end else if (paddr == TVM_OFF_STAT) begin
            prdata = {26'h000_0000, state_r, sup_err_r, tail_r,
                      state_r == TVM_ST_DONE};
         end
      end
   end

endmodule : tvm_layout

// ### dv/tvm_properties.sv
// Checker: port-level properties of the layout block
`timescale 1ns/1ps
module tvm_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic fetch_valid,
   input wire logic fetch_unmapped,
   input wire logic xlate_error_r
);
   import tvm_pkg::*;
   // ****
   // Helpers
   // ****
   logic [3:0] bad_d_r;
   wire logic bad_fetch = fetch_valid & fetch_unmapped;
   wire logic acc = psel & penable;
   wire logic clr_req = acc & pwrite & (paddr == TVM_OFF_FAULT) &
      pstrb[0] & pwdata[0];
   wire logic bad_addr = (paddr > TVM_OFF_STAT) | (paddr[1:0] != 2'h0);
   // Synchroniser latency is hidden from us, so keep a short history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_d_r <= 4'h0;
      end else begin
         bad_d_r <= {bad_d_r[2:0], bad_fetch};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_bad_fetch;
      fetch_valid && fetch_unmapped;
   endsequence
   sequence s_clear_quiet;
      clr_req && !bad_fetch && bad_d_r == 4'h0;
   endsequence
   property p_fault_set;
      s_bad_fetch |-> ##[1:4] xlate_error_r;
   endproperty
   property p_fault_hold;
      xlate_error_r && !clr_req |=> xlate_error_r;
   endproperty
   property p_fault_clear;
      s_clear_quiet |=> !xlate_error_r;
   endproperty
   property p_fault_cause;
      $rose(xlate_error_r) |-> bad_d_r != 4'h0;
   endproperty
   property p_fault_read;
      acc && !pwrite && paddr == TVM_OFF_FAULT |-> prdata[0] == xlate_error_r;
   endproperty
   property p_ready;
      acc |-> pready;
   endproperty
   property p_idle_quiet;
      !acc |-> prdata == 32'h0000_0000 && !pslverr;
   endproperty
   property p_refuse;
      acc && bad_addr |-> pslverr && (pwrite || prdata == 32'h0000_0000);
   endproperty
   property p_accept;
      acc && !bad_addr |-> !pslverr;
   endproperty
   a_fault_set: assert property (p_fault_set)
      else $error("fault flag missed an unmapped fetch");
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault flag dropped without a clear");
   a_fault_clear: assert property (p_fault_clear)
      else $error("fault flag ignored a clear");
   a_fault_cause: assert property (p_fault_cause)
      else $error("fault flag rose without a bad fetch");
   a_fault_read: assert property (p_fault_read)
      else $error("fault read differs from flag");
   a_ready: assert property (p_ready)
      else $error("ready low in access phase");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("read data or error outside access phase");
   a_refuse: assert property (p_refuse)
      else $error("bad address not refused");
   a_accept: assert property (p_accept)
      else $error("good address refused");
endmodule : tvm_properties

bind tvm_layout tvm_properties i_tvm_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fetch_valid(fetch_valid), .fetch_unmapped(fetch_unmapped),
   .xlate_error_r(xlate_error_r)
);

// ### dv/tvm_fetch_model.sv
// Partner model: sampler fetch stream seen by the translation check
`timescale 1ns/1ps
module tvm_fetch_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [3:0] beats,
   input wire logic unmapped,
   output logic fetch_valid,
   output logic fetch_unmapped
);
   logic [3:0] left_r;
   logic bad_r;
   logic junk_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_r <= 4'h0;
         bad_r <= 1'h0;
      end else if (start) begin
         left_r <= beats;
         bad_r <= unmapped;
      end else if (left_r != 4'h0) begin
         left_r <= left_r - 4'h1;
      end
   end
   // Toggles when idle so a design that ignores valid gets caught
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         junk_r <= 1'h0;
      end else begin
         junk_r <= ~junk_r;
      end
   end
   assign fetch_valid = left_r != 4'h0;
   // Only the overfetched last line may land in a hole
   assign fetch_unmapped = fetch_valid ? bad_r && left_r == 4'h1 : junk_r;
endmodule : tvm_fetch_model

// ### dv/test_tiled_volume_mip_layout.sv
// Testbench: layout block registers checked against a behavioural model
`timescale 1ns/1ps
module test_tiled_volume_mip_layout;
   import tvm_pkg::*;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic start = 1'h0;
   logic bad = 1'h0;
   logic [3:0] beats = 4'h1;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic fetch_valid;
   logic fetch_unmapped;
   logic xlate_error_r;
   logic [31:0] rd;
   logic err;
   logic flt = 1'h0;
   int failures = 0;
   int compares = 0;
   int seed = 6;
   int sm, rel, first, lvl;
   int lrel[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
   int srel[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11};
   int fp[6] = '{4, 5, 6, 8, 10, 12};
   logic [11:0] ra[5] = '{TVM_OFF_CTRL, TVM_OFF_FMT, TVM_OFF_LEVEL,
      TVM_OFF_BASE, TVM_OFF_DESC};
   logic [31:0] rv[5] = '{TVM_RST_CTRL, TVM_RST_FMT, TVM_RST_LEVEL,
      TVM_RST_BASE, TVM_RST_DESC};
   always #5 pclk = ~pclk;
   tvm_layout i_tvm_layout (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fetch_valid(fetch_valid), .fetch_unmapped(fetch_unmapped),
      .xlate_error_r(xlate_error_r));
   tvm_fetch_model i_tvm_fetch_model (.pclk(pclk), .presetn(presetn),
      .start(start), .beats(beats), .unmapped(bad),
      .fetch_valid(fetch_valid), .fetch_unmapped(fetch_unmapped));
   // ****
   // Tasks
   // ****
   task automatic end_of_test;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic int rnd(input int n);
      return $unsigned($random(seed)) % n;
   endfunction : rnd
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'h1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'h1) break;
      end
      if (n == 20) begin
         failures++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   task automatic cfg(input int tr, s, bw, f, l);
      logic [31:0] base, pos, aln;
      int u, v, r, h, va, dp, sl, tl;
      base = $random(seed);
      tl = tr != 0 && l >= f;
      sl = l - f + (s ? 4 : 0);
      u = 0;
      v = 0;
      r = 0;
      if (tl) begin
         case (sl)
            0: u = bw == 4 ? 8 : bw == 0 ? 32 : 16;
            1: v = bw >= 3 ? 8 : 16;
            2: r = bw <= 1 ? 16 : 8;
            3: u = bw == 4 ? 4 : bw == 0 ? 16 : 8;
            4: v = bw >= 3 ? 4 : 8;
            5: r = bw <= 1 ? 8 : 4;
            6: begin
               u = bw == 4 ? 3 : bw == 3 ? 6 : bw == 2 ? 4 : 0;
               v = bw <= 2 ? 4 : 0;
               r = bw <= 1 ? 4 : 0;
            end
            7: begin
               u = bw == 4 ? 2 : bw == 3 ? 4 : 0;
               v = bw <= 2 ? 4 : 0;
            end
            8, 9, 10, 11: begin
               u = bw == 4 ? 1 : bw == 3 ? 2 : bw == 2 ? 4 : 0;
               r = (bw <= 1 ? 15 : 11) - sl;
            end
            default: r = 15 - sl;
         endcase
      end
      h = bw == 4 ? 16 : bw == 0 ? 64 : 32;
      va = bw >= 3 ? 16 : 32;
      dp = bw <= 1 ? 32 : 16;
      if (s) begin
         h = h / 4;
         va = va / 2;
         dp = dp / 2;
      end
      if (bw > 4) begin
         h = 0;
         va = 0;
         dp = 0;
         u = 0;
         v = 0;
         r = 0;
      end
      pos = {base[31:16] + 16'(v), base[15:0] + 16'(u)};
      aln = {8'(r), 8'(h), 8'(va), 8'(dp)};
      apb(1'h1, TVM_OFF_DESC, $random(seed), 4'hF);
      apb(1'h1, TVM_OFF_CTRL, (s << 2) | tr, 4'hF);
      apb(1'h1, TVM_OFF_FMT, bw, 4'hF);
      apb(1'h1, TVM_OFF_LEVEL, (f << 8) | l, 4'hF);
      apb(1'h1, TVM_OFF_BASE, base, 4'hF);
      repeat (2) @(posedge pclk);
      apb(1'h0, TVM_OFF_STAT, '0, 4'h0);
      chk(rd[1], tl[0]);
      chk(rd[2], bw > 4);
      chk({rd[5:3], rd[0]}, 4'h9);
      apb(1'h0, TVM_OFF_ALIGN, '0, 4'h0);
      chk(rd, aln);
      apb(1'h0, TVM_OFF_POS, '0, 4'h0);
      chk(rd, pos);
   endtask : cfg
   task automatic unit(input int s, c, fw, fh);
      logic [15:0] dsc;
      int i, j;
      dsc = 16'($random(seed));
      i = s == 1 ? (c == 4 ? 8 : 4) : s == 2 ? 8 : c == 1 ? 4 :
         c == 2 ? 8 : c == 3 ? fw : dsc[7:0];
      j = s == 1 ? 4 : s == 2 ? 8 : c == 1 || c == 2 ? 4 :
         c == 3 ? fh * 4 : dsc[15:8];
      apb(1'h1, TVM_OFF_DESC, dsc, 4'hF);
      apb(1'h1, TVM_OFF_FMT, (fh << 16) | (fw << 12) | (c << 8) | (s << 4) | 2,
         4'hF);
      repeat (2) @(posedge pclk);
      apb(1'h0, TVM_OFF_UNIT, '0, 4'h0);
      chk(rd, {16'h0000, 8'(j), 8'(i)});
   endtask : unit
   task automatic fetch(input logic b, input logic [3:0] n);
      start <= 1'h1;
      bad <= b;
      beats <= n;
      @(posedge pclk);
      start <= 1'h0;
      repeat (n + 6) @(posedge pclk);
      flt = flt | b;
      apb(1'h0, TVM_OFF_FAULT, '0, 4'h0);
      chk(rd[0], flt);
   endtask : fetch
   task automatic fclr(input logic [31:0] d);
      apb(1'h1, TVM_OFF_FAULT, d, 4'hF);
      if (d[0]) flt = 1'h0;
      apb(1'h0, TVM_OFF_FAULT, '0, 4'h0);
      chk(rd[0], flt);
   endtask : fclr
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      foreach (ra[k]) begin
         apb(1'h0, ra[k], '0, 4'h0);
         chk(rd, rv[k]);
      end
      apb(1'h0, 12'h028, '0, 4'h0);
      chk(rd, 32'h0000_0000);
      chk(err, 1'h1);
      apb(1'h1, 12'h006, 32'hFFFF_FFFF, 4'hF);
      chk(err, 1'h1);
      apb(1'h0, TVM_OFF_FMT, '0, 4'h0);
      chk(rd, TVM_RST_FMT);
      apb(1'h1, TVM_OFF_DESC, 32'hFFFF_FFAB, 4'h1);
      apb(1'h0, TVM_OFF_DESC, '0, 4'h0);
      chk(rd, 32'h0000_04AB);
      for (int s = 0; s < 3; s++) begin
         for (int c = 0; c < 5; c++) begin
            if (s != 0 || c != 4) unit(s, c, fp[rnd(6)], fp[rnd(6)]);
         end
      end
      for (int b = 0; b < 8; b++) begin
         foreach (lrel[j]) cfg(1, 0, b, 0, lrel[j]);
         foreach (srel[j]) cfg(2, 1, b, 15 - srel[j], 15);
      end
      for (int k = 0; k < 40; k++) begin
         sm = rnd(2);
         rel = sm ? srel[rnd(12)] : lrel[rnd(16)];
         first = rnd(16 - rel);
         lvl = (k % 4 == 0 && first > 0) ? first - 1 : first + rel;
         cfg(rnd(4), sm, rnd(5), first, lvl);
      end
      fetch(1'h0, 4'h3);
      fetch(1'h1, 4'h1);
      fetch(1'h0, 4'h8);
      fclr(32'h0000_0000);
      fclr(32'h0000_0001);
      fetch(1'h1, 4'h6);
      fclr(32'h0000_0001);
      end_of_test();
   end
endmodule : test_tiled_volume_mip_layout
